// *** verilog/dcr_map.svh ***
// Register offsets, field positions and reset values of the converter control bank
// Assumes byte addressing on a 32-bit APB bus, one aligned word per register
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
`define DCR_CTRL_OFFSET   12'h000
`define DCR_LEVEL_OFFSET  12'h004
`define DCR_EN_BIT        7
`define DCR_OUT1_BIT      5
`define DCR_OUT2_BIT      4
`define DCR_PREF_BIT      2
`define DCR_CTRL_MASK     8'hb4
`define DCR_LEVEL_MASK    8'h1f
`define DCR_CTRL_RESET    8'h00
`define DCR_LEVEL_RESET   5'h00
`define DCR_ADDR_W        12
`endif

// *** verilog/dcr_pkg.sv ***
// Types shared by the converter control bank
// Assumes the map header supplies widths and offsets
`include "dcr_map.svh"
package dcr_pkg;
  typedef struct packed {
    logic       converter_enable;
    logic       output_one_connect;
    logic       output_two_connect;
    logic       positive_reference_select;
    logic [4:0] output_level_field;
  } dcr_ctrl_t;

  typedef enum logic {
    DCR_PH_IDLE  = 1'b0,
    DCR_PH_READY = 1'b1
  } dcr_phase_t;
endpackage

// *** verilog/dcr_top.sv ***
// APB register bank for the voltage reference converter controls
// Assumes an APB master on pclk; the analogue converter reads the control outputs
//
// Behaviour
// - Control bit 7 enables the converter
// - Bits 5 and 4 connect output pins
// - Level register bits 4-0 select step
// - Unimplemented bits read zero, ignore writes
// - All implemented bits reset to zero
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "dcr_map.svh"
module dcr_top
  import dcr_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`DCR_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output dcr_ctrl_t                    ctrl
);

  localparam logic [7:0] CTRL_MASK  = `DCR_CTRL_MASK;
  localparam logic [7:0] LEVEL_MASK = `DCR_LEVEL_MASK;
  localparam logic [7:0] CTRL_RST   = `DCR_CTRL_RESET;
  localparam logic [4:0] LEVEL_RST  = `DCR_LEVEL_RESET;

  // Bus phase decode
  logic        setup_phase;
  logic        access_phase;
  logic        hit_ctrl;
  logic        hit_level;
  logic        hit_none;
  logic        wr_strobe;
  logic        wr_ctrl;
  logic        wr_level;
  logic        rd_ctrl;
  logic        rd_level;
  logic        err_setup;

  // Control register
  logic [7:0]  ctrl_word_q;
  logic [7:0]  ctrl_word_d;
  logic [7:0]  ctrl_wr_bits;
  logic [7:0]  ctrl_rd_bits;

  // Level register
  logic [7:0]  level_word_q;
  logic [7:0]  level_word_d;
  logic [7:0]  level_wr_bits;
  logic [7:0]  level_rd_bits;

  // Transfer phase
  dcr_phase_t  phase_q;
  dcr_phase_t  phase_d;

  // Bus response
  logic        pready_d;
  logic        pslverr_d;
  logic [31:0] prdata_d;

  // Converter outputs
  dcr_ctrl_t   ctrl_d;

  // Setup cycle opens a transfer, the ready cycle closes it
  always_comb begin
    setup_phase  = 1'b0;
    access_phase = 1'b0;

    if (psel) begin
      if (penable) begin
        access_phase = pready;
      end else begin
        setup_phase = 1'b1;
      end
    end
  end

  // Address match
  always_comb begin
    hit_ctrl  = 1'b0;
    hit_level = 1'b0;
    hit_none  = 1'b0;

    if (paddr == `DCR_CTRL_OFFSET) begin
      hit_ctrl = 1'b1;
    end else if (paddr == `DCR_LEVEL_OFFSET) begin
      hit_level = 1'b1;
    end else begin
      hit_none = 1'b1;
    end
  end

  // Writes land on the ready edge
  always_comb begin
    wr_strobe = access_phase && pwrite && pstrb[0];
    wr_ctrl   = wr_strobe && hit_ctrl;
    wr_level  = wr_strobe && hit_level;
  end

  // Reads and errors are prepared in the setup cycle
  always_comb begin
    rd_ctrl   = setup_phase && !pwrite && hit_ctrl;
    rd_level  = setup_phase && !pwrite && hit_level;
    err_setup = setup_phase && hit_none;
  end

  // Unimplemented bits are dropped on write and on read
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_mask_bit
      assign ctrl_wr_bits[bit_idx]  = CTRL_MASK[bit_idx] & pwdata[bit_idx];
      assign ctrl_rd_bits[bit_idx]  = CTRL_MASK[bit_idx] & ctrl_word_q[bit_idx];
      assign level_wr_bits[bit_idx] = LEVEL_MASK[bit_idx] & pwdata[bit_idx];
      assign level_rd_bits[bit_idx] = LEVEL_MASK[bit_idx] & level_word_q[bit_idx];
    end
  endgenerate

  // Control register next value
  always_comb begin
    ctrl_word_d = ctrl_word_q;

    if (wr_ctrl) begin
      ctrl_word_d = ctrl_wr_bits;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_word_q <= CTRL_RST;
    end else begin
      ctrl_word_q <= ctrl_word_d;
    end
  end

  // Level register next value
  always_comb begin
    level_word_d = level_word_q;

    if (wr_level) begin
      level_word_d = level_wr_bits;
    end
  end

  // Level register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_word_q <= {3'h0, LEVEL_RST};
    end else begin
      level_word_q <= level_word_d;
    end
  end

  // Converter outputs mirror the register words
  always_comb begin
    ctrl_d.converter_enable          = ctrl_word_d[`DCR_EN_BIT];
    ctrl_d.output_one_connect        = ctrl_word_d[`DCR_OUT1_BIT];
    ctrl_d.output_two_connect        = ctrl_word_d[`DCR_OUT2_BIT];
    ctrl_d.positive_reference_select = ctrl_word_d[`DCR_PREF_BIT];
    ctrl_d.output_level_field        = level_word_d[4:0];
  end

  // Converter outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.converter_enable          <= 1'b0;
      ctrl.output_one_connect        <= 1'b0;
      ctrl.output_two_connect        <= 1'b0;
      ctrl.positive_reference_select <= 1'b0;
      ctrl.output_level_field        <= LEVEL_RST;
    end else begin
      ctrl <= ctrl_d;
    end
  end

  // Ready follows every setup cycle, no wait states
  always_comb begin
    phase_d = phase_q;

    unique case (phase_q)
      DCR_PH_IDLE: begin
        if (setup_phase) begin
          phase_d = DCR_PH_READY;
        end
      end
      DCR_PH_READY: begin
        phase_d = DCR_PH_IDLE;
      end
    endcase
  end

  // Transfer phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= DCR_PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Ready stands for one cycle
  always_comb begin
    pready_d = 1'b0;

    if (phase_d == DCR_PH_READY) begin
      pready_d = 1'b1;
    end
  end

  // Ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_d;
    end
  end

  // Unmapped addresses answer with an error
  always_comb begin
    pslverr_d = 1'b0;

    if (err_setup) begin
      pslverr_d = 1'b1;
    end
  end

  // Error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

  // Read data stands only in the ready cycle
  always_comb begin
    prdata_d = 32'h0000_0000;

    if (rd_ctrl) begin
      prdata_d[7:0] = ctrl_rd_bits;
    end

    if (rd_level) begin
      prdata_d[7:0] = level_rd_bits;
    end
  end

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_d;
    end
  end

  // Bits above the low byte never carry data
  // A write with the low strobe clear leaves both registers as they are
  // A read of an unmapped address returns zero with the error flag

endmodule

// *** tb/dcr_props.sv ***
// Checker on the converter control bank ports
// Assumes a bind to dcr_top from the bench top file
`timescale 1ns/1ps
module dcr_props
  import dcr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire dcr_ctrl_t   ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ready_edge;
    psel && penable && pready;
  endsequence
  sequence s_write(logic [11:0] addr);
    s_ready_edge ##0 (pwrite && pstrb[0] && paddr == addr);
  endsequence
  a_en_wr: assert property (s_write(12'h000) |=> ctrl[8] == $past(pwdata[7])) else $error("en");
  a_pin_wr: assert property (s_write(12'h000) |=> ctrl[7:6] == $past(pwdata[5:4])) else $error("pin");
  a_lvl_wr: assert property (s_write(12'h004) |=> ctrl[4:0] == $past(pwdata[4:0])) else $error("lvl");
  a_err_unmap: assert property (s_ready_edge ##0 (paddr != 12'h000 && paddr != 12'h004) |-> pslverr) else $error("err");
  a_strb_keep: assert property (s_ready_edge ##0 (pwrite && !pstrb[0]) |=> $stable(ctrl)) else $error("strb");
  a_rsv_zero: assert property (pready |-> (prdata & (paddr == 12'h000 ? 32'hffffff4b : 32'hffffffe0)) == 32'h0) else $error("rsv");
  a_rst_zero: assert property ($rose(presetn) |-> ctrl == 9'h000) else $error("rst");
  a_ref_wr: assert property (s_write(12'h000) |=> ctrl[5] == $past(pwdata[2])) else $error("ref");
endmodule

// *** tb/testbench.sv ***
// Bench for the converter control bank
// Assumes dcr_top and dcr_props are compiled first
`timescale 1ns/1ps
module testbench;
  import dcr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  dcr_ctrl_t   ctrl;
  logic [31:0] rd_data;
  logic        rd_err;
  int          error_cnt = 0;
  int          cmp_count = 0;
  dcr_top dcr_top_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctrl    (ctrl)
  );
  always #4 pclk = ~pclk;
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t flag got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_ctrl(input dcr_ctrl_t got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ctrl got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_ctrl;
    apb_xfer(1'b1, 12'h000, 32'h000000ff, 4'hf);
    check_flag(rd_err, 1'b0);
    apb_xfer(1'b0, 12'h000, 32'h0, 4'hf);
    check_word(rd_data, 32'h000000b4);
    check_ctrl(ctrl, 9'h1e0);
    apb_xfer(1'b1, 12'h000, 32'h0000004b, 4'hf);
    apb_xfer(1'b0, 12'h000, 32'h0, 4'hf);
    check_word(rd_data, 32'h00000000);
    check_ctrl(ctrl, 9'h000);
    apb_xfer(1'b1, 12'h000, 32'h00000024, 4'hf);
    apb_xfer(1'b0, 12'h000, 32'h0, 4'hf);
    check_word(rd_data, 32'h00000024);
    check_ctrl(ctrl, 9'h0a0);
    $display("control test done");
  endtask
  task automatic t_level;
    apb_xfer(1'b1, 12'h004, 32'hffffffff, 4'hf);
    apb_xfer(1'b0, 12'h004, 32'h0, 4'hf);
    check_word(rd_data, 32'h0000001f);
    check_ctrl(ctrl, 9'h0bf);
    apb_xfer(1'b1, 12'h004, 32'h0000000a, 4'hf);
    apb_xfer(1'b0, 12'h004, 32'h0, 4'hf);
    check_word(rd_data, 32'h0000000a);
    check_ctrl(ctrl, 9'h0aa);
    $display("level test done");
  endtask
  task automatic t_refuse;
    apb_xfer(1'b1, 12'h000, 32'h000000ff, 4'he);
    apb_xfer(1'b0, 12'h000, 32'h0, 4'hf);
    check_word(rd_data, 32'h00000024);
    apb_xfer(1'b1, 12'h008, 32'h000000ff, 4'hf);
    check_flag(rd_err, 1'b1);
    apb_xfer(1'b0, 12'h008, 32'h0, 4'hf);
    check_word(rd_data, 32'h00000000);
    check_flag(rd_err, 1'b1);
    check_ctrl(ctrl, 9'h0aa);
    $display("refuse test done");
  endtask
  task automatic t_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check_ctrl(ctrl, 9'h000);
    presetn <= 1'b1;
    @(posedge pclk);
    apb_xfer(1'b0, 12'h000, 32'h0, 4'hf);
    check_word(rd_data, 32'h00000000);
    apb_xfer(1'b0, 12'h004, 32'h0, 4'hf);
    check_word(rd_data, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl();
    t_level();
    t_refuse();
    t_reset();
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge pclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
bind dcr_top dcr_props dcr_props_inst (
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .pstrb   (pstrb),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr),
  .ctrl    (ctrl)
);
